// >>> design/cafab_core.sv
`timescale 1ns/10ps
`default_nettype none
`include "cafab_regs.svh"
// Function
// [RULE1] keep four flags N Z S C; ALU results set them, branches test them
// [RULE2] subtract and compare are a+~b+1, sub-with-carry a+~b+C; all four flags
// [RULE3] negate/xor/load/or/and/test set only N and Z; store sets none
// [RULE4] register mode shifts source, applies op with destination, writes back
// [RULE5] immediate mode uses 6 or 16 bit immediate, result to destination
// [RULE6] direct mode addresses memory by 6 or 16 bit operand; store writes reg
// [RULE7] indirect address from source; pre-increment or post inc/dec by one
// [RULE8] data-segment qualifier supplies upper 6 address bits, else zero
// [RULE9] multi-register push/pop via stack pointer, adjusted per register
// [RULE10] displacement address is base pointer plus 6 bit displacement
// [RULE11] select 0 stack, 1-4 general or shadow, 5 base, 6 status, 7 pc
// [RULE12] status word holds code and data segment plus the four flags
// [RULE13] flag word holds divide sign, bank, fraction, move, guard, irq bits
// [RULE14] simple branches test one flag; unconditional jump always taken
// [RULE15] above, greater, their negations, overflow on N differing from S
// [RULE16] cycles grow by read waits per read, write waits per write; displacement stores and pushes are costed with read waits
// [RULE17] multiply-accumulate takes 1..16 elements; write waits if auto move
// [RULE18] destination program counter costs one extra cycle; register mode adds 2 instead
// [RULE19] N copies result bit 15; Z set when result is all zero
// [RULE20] bank bit of flag word steers general/shadow remap for next op
module cafab_core (
  input  wire logic                   core_clk_i,    // core clock
  input  wire logic                   rst_n_i,       // async reset, low
  input  wire cafab_pkg::cafab_instr_s instr_i,      // decoded instruction
  input  wire logic                   instr_valid_i, // instruction offered
  output logic                        instr_ready_o, // core idle
  output logic                        done_o,        // last cycle of op
  output cafab_pkg::cafab_mem_s       mem_o,         // data memory request
  input  wire logic [15:0]            mem_rdata_i,   // data memory read
  input  wire logic [3:0]             reg_addr_i,    // register port addr
  input  wire logic [15:0]            reg_wdata_i,   // register port data
  input  wire logic                   reg_wr_i,      // register write
  input  wire logic                   reg_rd_i,      // register read
  output logic [15:0]                 reg_rdata_o    // read data, next cycle
);
  import cafab_pkg::*;

  cafab_state_s cur_r;
  cafab_state_s cur_nxt;
  logic         accept;
  logic         done_w;
  cafab_alu_s   alu;
  logic [15:0]  op_a;
  logic [15:0]  op_b;
  logic         alu_mode;
  logic         wb_en;
  logic         upd_all;
  logic         upd_nz;
  logic [9:0]   elap_r;

  // register select decode, bank bit remaps 1..4
  function automatic logic [15:0] f_reg(input cafab_state_s s,
                                        input logic [2:0] sel);
    logic [1:0] gi;
    gi = 2'(sel - 3'h1);
    case (sel)
      3'h0:    f_reg = s.sp;
      3'h5:    f_reg = s.bp;
      3'h6:    f_reg = s.sr;
      3'h7:    f_reg = s.pc;
      default: f_reg = s.fr[`CAFAB_FR_BNK] ? s.shd[gi] : s.gen[gi]; // [RULE11] [RULE20]
    endcase
  endfunction : f_reg

  // register select write
  function automatic cafab_state_s f_wr(input cafab_state_s s,
                                        input logic [2:0] sel,
                                        input logic [15:0] v);
    logic [1:0] gi;
    gi = 2'(sel - 3'h1);
    f_wr = s;
    case (sel)
      3'h0:    f_wr.sp = v;
      3'h5:    f_wr.bp = v;
      3'h6:    f_wr.sr = v; // [RULE12]
      3'h7:    f_wr.pc = v;
      default:
      begin
        if (s.fr[`CAFAB_FR_BNK])
          f_wr.shd[gi] = v; // [RULE11]
        else
          f_wr.gen[gi] = v;
      end
    endcase
  endfunction : f_wr

  // source shift by 1..4 places
  function automatic logic [15:0] f_shift(input logic [15:0] v,
                                          input cafab_shift_e sh,
                                          input logic [1:0] amt);
    logic [4:0] n;
    n = {3'h0, amt} + 5'd1;
    case (sh)
      SH_ASR:  f_shift = $signed(v) >>> n;
      SH_LSL:  f_shift = v << n;
      SH_LSR:  f_shift = v >> n;
      SH_ROL:  f_shift = (v << n) | (v >> (5'd16 - n));
      SH_ROR:  f_shift = (v >> n) | (v << (5'd16 - n));
      default: f_shift = v;
    endcase
  endfunction : f_shift

  // result and flags; S is the sign of the exact 17 bit result
  function automatic cafab_alu_s f_alu(input cafab_alu_e op,
                                       input logic [15:0] a,
                                       input logic [15:0] b,
                                       input logic cin);
    logic [15:0] bb;
    logic        ci;
    logic [16:0] u;
    logic [16:0] sx;
    bb = b;
    ci = 1'b0;
    if (op inside {ALU_SUB, ALU_SBC, ALU_CMP})
    begin
      bb = ~b; // [RULE2]
      ci = (op == ALU_SBC) ? cin : 1'b1;
    end
    else if (op == ALU_ADC)
      ci = cin;
    u  = {1'b0, a} + {1'b0, bb} + {16'h0000, ci};
    sx = {a[15], a} + {bb[15], bb} + {16'h0000, ci};
    f_alu.c = u[16];
    f_alu.s = sx[16];
    case (op)
      ALU_NEG:  f_alu.res = ~b + 16'h0001;
      ALU_XOR:  f_alu.res = a ^ b;
      ALU_LOAD: f_alu.res = b;
      ALU_OR:   f_alu.res = a | b;
      ALU_AND,
      ALU_TEST: f_alu.res = a & b;
      ALU_STORE: f_alu.res = a;
      default:  f_alu.res = u[15:0];
    endcase
    f_alu.n = f_alu.res[15];              // [RULE19]
    f_alu.z = (f_alu.res == 16'h0000);    // [RULE19]
  endfunction : f_alu

  // branch condition from status flags
  function automatic logic f_take(input cafab_cond_e c,
                                  input logic [15:0] sr);
    logic n;
    logic z;
    logic s;
    logic cy;
    n  = sr[`CAFAB_SR_N];
    z  = sr[`CAFAB_SR_Z];
    s  = sr[`CAFAB_SR_S];
    cy = sr[`CAFAB_SR_C];
    case (c)
      BR_CC:   f_take = !cy;             // [RULE14]
      BR_CS:   f_take = cy;
      BR_SC:   f_take = !s;
      BR_SS:   f_take = s;
      BR_NE:   f_take = !z;
      BR_EQ:   f_take = z;
      BR_PL:   f_take = !n;
      BR_MI:   f_take = n;
      BR_BE:   f_take = !(!z && cy);     // [RULE15]
      BR_A:    f_take = !z && cy;
      BR_LE:   f_take = !(!z && !s);
      BR_G:    f_take = !z && !s;
      BR_VC:   f_take = (n == s);
      BR_VS:   f_take = (n != s);
      default: f_take = 1'b1;            // [RULE14]
    endcase
  endfunction : f_take

  // total cycles of one instruction
  function automatic logic [9:0] f_total(input cafab_instr_s i,
                                         input logic [3:0] rw4,
                                         input logic [3:0] sw4,
                                         input logic auto_move_mode_bit,
                                         input logic tk);
    logic [9:0] rw;
    logic [9:0] sw;
    logic [9:0] access_wait_count;
    logic [9:0] n;
    logic [9:0] px;
    rw  = {6'h00, rw4};
    sw  = {6'h00, sw4};
    access_wait_count = (i.alu == ALU_STORE) ? sw : rw; // [RULE16]
    n   = {6'h00, i.cnt} + 10'd1;         // [RULE17]
    px  = (i.rd == 3'h7 && !(i.alu inside {ALU_CMP, ALU_TEST, ALU_STORE}))
          ? `CAFAB_CYC_PC : 10'd0;        // [RULE18]
    case (i.mode)
      MD_REG:   f_total = `CAFAB_CYC_REG + rw
                          + (px != 10'd0 ? `CAFAB_CYC_REG_PC : 10'd0);
      MD_IMM6:  f_total = `CAFAB_CYC_IMM6 + rw + px;
      MD_IMM16: f_total = `CAFAB_CYC_IMM16 + 10'd2 * rw + px;
      MD_DIR6:  f_total = `CAFAB_CYC_DIR6 + rw + access_wait_count + px;
      MD_DIR16: f_total = `CAFAB_CYC_DIR16 + 10'd2 * rw + access_wait_count + px;
      MD_IND:   f_total = `CAFAB_CYC_IND + rw + access_wait_count + px;
      MD_DISP:  f_total = `CAFAB_CYC_DISP + 10'd2 * rw + px;
      MD_MULTI:
      begin
        n = {7'h00, 3'(i.rs - i.rd)} + 10'd1;
        f_total = `CAFAB_CYC_MULTI + 10'd2 * n + (n + 10'd1) * rw;
      end
      MD_BRANCH: f_total = (tk ? `CAFAB_CYC_BR_TK : `CAFAB_CYC_BR) + rw;
      MD_MAC:   f_total = `CAFAB_CYC_MAC + `CAFAB_CYC_MAC_N * n
                          + (n + 10'd1) * 10'd2 * rw
                          + (auto_move_mode_bit ? n * sw : 10'd0); // [RULE17]
      default:  f_total = `CAFAB_CYC_REG + rw;
    endcase
  endfunction : f_total

  // operand selection per addressing mode and the ALU
  always_comb
  begin
    op_a = f_reg(cur_r, cur_r.ins.rd);
    op_b = cur_r.mdat;
    case (cur_r.ins.mode)
      MD_REG:   op_b = f_shift(f_reg(cur_r, cur_r.ins.rs), cur_r.ins.shift,
                               cur_r.ins.sh_amt); // [RULE4]
      MD_IMM6:  op_b = {10'h000, cur_r.ins.imm[5:0]}; // [RULE5]
      MD_IMM16:
      begin
        op_a = f_reg(cur_r, cur_r.ins.rs); // [RULE5]
        op_b = cur_r.ins.imm;
      end
      MD_DIR16: op_a = f_reg(cur_r, cur_r.ins.rs); // [RULE6]
      default:  op_b = cur_r.mdat;
    endcase
    alu = f_alu(cur_r.ins.alu, op_a, op_b, cur_r.sr[`CAFAB_SR_C]);
    alu_mode = cur_r.ins.mode inside {MD_REG, MD_IMM6, MD_IMM16, MD_DIR6,
                                      MD_DIR16, MD_IND, MD_DISP};
    upd_all = alu_mode && (cur_r.ins.alu inside {ALU_ADD, ALU_ADC, ALU_SUB,
                                                 ALU_SBC, ALU_CMP});
    upd_nz  = alu_mode && (cur_r.ins.alu inside {ALU_NEG, ALU_XOR,
                           ALU_LOAD, ALU_OR, ALU_AND, ALU_TEST}); // [RULE3]
    wb_en   = alu_mode && !(cur_r.ins.alu inside {ALU_CMP, ALU_TEST,
                                                  ALU_STORE});
  end

  assign accept        = instr_valid_i && (cur_r.st == ST_IDLE);
  assign done_w        = (cur_r.st == ST_PAD) && (cur_r.cnt == 10'd0);
  assign instr_ready_o = (cur_r.st == ST_IDLE);
  assign done_o        = done_w;
  assign mem_o         = cur_r.mem;
  assign reg_rdata_o   = cur_r.rdata;

  // next state: register port, access sequencing, completion
  always_comb
  begin
    logic [15:0] a16;
    logic [15:0] rv;
    logic        go;
    a16 = 16'h0000;
    rv  = f_reg(cur_r, cur_r.ins.rs);
    go  = 1'b0;
    cur_nxt = cur_r;
    if (reg_wr_i)
    begin
      case (reg_addr_i)
        `CAFAB_OFS_FLAG:  cur_nxt.fr = reg_wdata_i; // [RULE13] [RULE20]
        `CAFAB_OFS_RWAIT: cur_nxt.rw = reg_wdata_i[3:0];
        `CAFAB_OFS_SWAIT: cur_nxt.sw = reg_wdata_i[3:0];
        default:
        begin
          if (!reg_addr_i[3])
            cur_nxt = f_wr(cur_nxt, reg_addr_i[2:0], reg_wdata_i);
        end
      endcase
    end
    cur_nxt.rdata = 16'h0000;
    if (reg_rd_i)
    begin
      case (reg_addr_i)
        `CAFAB_OFS_FLAG:  cur_nxt.rdata = cur_r.fr;
        `CAFAB_OFS_RWAIT: cur_nxt.rdata = {12'h000, cur_r.rw};
        `CAFAB_OFS_SWAIT: cur_nxt.rdata = {12'h000, cur_r.sw};
        `CAFAB_OFS_STATE: cur_nxt.rdata = {cur_r.st != ST_IDLE, 5'h00,
                                           cur_r.cnt};
        default:
        begin
          if (!reg_addr_i[3])
            cur_nxt.rdata = f_reg(cur_r, reg_addr_i[2:0]); // [RULE11]
        end
      endcase
    end
    case (cur_r.st)
      ST_IDLE:
      begin
        if (accept)
        begin
          cur_nxt.ins = instr_i;
          cur_nxt.cnt = f_total(instr_i, cur_r.rw, cur_r.sw,
                                cur_r.fr[`CAFAB_FR_FIR],
                                f_take(instr_i.cond, cur_r.sr))
                        - 10'd1; // [RULE16]
          cur_nxt.st  = ST_PAD;
          cur_nxt.mem.addr[21:16] = 6'h00;
          cur_nxt.mem.wr = (instr_i.alu == ALU_STORE);
          cur_nxt.mem.wdata = f_reg(cur_r, instr_i.rd);
          rv = f_reg(cur_r, instr_i.rs);
          go = 1'b1;
          case (instr_i.mode)
            MD_DIR6:  a16 = {10'h000, instr_i.imm[5:0]}; // [RULE6]
            MD_DIR16: a16 = instr_i.imm;                 // [RULE6]
            MD_DISP:  a16 = cur_r.bp + {10'h000, instr_i.imm[5:0]}; // [RULE10]
            MD_IND:
            begin
              a16 = (instr_i.idx == IX_PREINC) ? rv + 16'h0001 : rv; // [RULE7]
              if (instr_i.ds_q)
                cur_nxt.mem.addr[21:16] =
                  cur_r.sr[`CAFAB_SR_DS_HI:`CAFAB_SR_DS_LO]; // [RULE8]
            end
            MD_MULTI:
            begin
              cur_nxt.left = {1'b0, 3'(instr_i.rs - instr_i.rd)} + 4'h1;
              cur_nxt.cur  = instr_i.push ? instr_i.rs : instr_i.rd;
              cur_nxt.mem.wr = instr_i.push; // [RULE9]
              cur_nxt.mem.wdata = f_reg(cur_r, instr_i.rs);
              a16 = instr_i.push ? cur_r.sp : cur_r.sp + 16'h0001;
            end
            default: go = 1'b0;
          endcase
          if (go)
          begin
            cur_nxt.st = ST_ACC;
            cur_nxt.mem.rd = !cur_nxt.mem.wr;
            cur_nxt.mem.addr[15:0] = a16;
            cur_nxt.wcnt = cur_nxt.mem.wr ? cur_r.sw : cur_r.rw; // [RULE16]
          end
        end
      end
      ST_ACC:
      begin
        cur_nxt.cnt = (cur_r.cnt == 10'd0) ? 10'd0 : cur_r.cnt - 10'd1;
        if (cur_r.wcnt != 4'h0)
          cur_nxt.wcnt = cur_r.wcnt - 4'h1;
        else
        begin
          cur_nxt.mdat = mem_rdata_i;
          cur_nxt.mem.rd = 1'b0;
          cur_nxt.mem.wr = 1'b0;
          cur_nxt.st = ST_PAD;
          if (cur_r.ins.mode == MD_MULTI)
          begin
            if (!cur_r.ins.push)
              cur_nxt = f_wr(cur_nxt, cur_r.cur, mem_rdata_i); // [RULE9]
            cur_nxt.sp = cur_r.ins.push ? cur_r.sp - 16'h0001
                                        : cur_r.sp + 16'h0001; // [RULE9]
            cur_nxt.left = cur_r.left - 4'h1;
            if (cur_r.left > 4'h1)
            begin
              cur_nxt.cur = cur_r.ins.push ? cur_r.cur - 3'h1
                                           : cur_r.cur + 3'h1;
              cur_nxt.mem.addr[15:0] = cur_r.ins.push ? cur_nxt.sp
                                       : cur_nxt.sp + 16'h0001;
              cur_nxt.mem.wdata = f_reg(cur_nxt, cur_nxt.cur);
              cur_nxt.mem.rd = !cur_r.ins.push;
              cur_nxt.mem.wr = cur_r.ins.push;
              cur_nxt.wcnt = cur_r.ins.push ? cur_r.sw : cur_r.rw;
              cur_nxt.st = ST_ACC;
            end
          end
        end
      end
      ST_PAD:
      begin
        cur_nxt.cnt = (cur_r.cnt == 10'd0) ? 10'd0 : cur_r.cnt - 10'd1;
        if (done_w)
        begin
          cur_nxt.st = ST_IDLE;
          cur_nxt.pc = cur_r.pc + ((cur_r.ins.mode inside {MD_IMM16,
                                   MD_DIR16}) ? 16'h0002 : 16'h0001);
          if (cur_r.ins.mode == MD_BRANCH && f_take(cur_r.ins.cond, cur_r.sr))
            cur_nxt.pc = cur_r.ins.imm; // [RULE14] [RULE15]
          if (cur_r.ins.mode == MD_IND && cur_r.ins.idx != IX_NONE)
            cur_nxt = f_wr(cur_nxt, cur_r.ins.rs,
                           (cur_r.ins.idx == IX_POSTDEC) ? rv - 16'h0001
                                                         : rv + 16'h0001); // [RULE7]
          if (wb_en)
            cur_nxt = f_wr(cur_nxt, cur_r.ins.rd, alu.res); // [RULE4]
          if (!(wb_en && cur_r.ins.rd == 3'h6))
          begin
            if (upd_all || upd_nz)
            begin
              cur_nxt.sr[`CAFAB_SR_N] = alu.n; // [RULE1] [RULE19]
              cur_nxt.sr[`CAFAB_SR_Z] = alu.z;
            end
            if (upd_all)
            begin
              cur_nxt.sr[`CAFAB_SR_S] = alu.s; // [RULE2]
              cur_nxt.sr[`CAFAB_SR_C] = alu.c;
            end
          end
        end
      end
      default: cur_nxt.st = ST_IDLE;
    endcase
  end

  // state register
  always_ff @(posedge core_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      cur_r <= '0;
    else
      cur_r <= cur_nxt;
  end

  // cycles since acceptance, read only by checks
  always_ff @(posedge core_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      elap_r <= 10'd0;
    else if (accept)
      elap_r <= 10'd1;
    else if (cur_r.st != ST_IDLE)
      elap_r <= elap_r + 10'd1;
  end

  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!rst_n_i);

  sequence s_flag_done;
    done_w && (upd_all || upd_nz) && !(wb_en && cur_r.ins.rd == 3'h6);
  endsequence
  sequence s_branch_done;
    done_w && cur_r.ins.mode == MD_BRANCH;
  endsequence

  a_neg_flag: assert property (s_flag_done |=> // [RULE19]
    cur_r.sr[`CAFAB_SR_N] == $past(alu.res[15]))
    else $error("negative flag not result bit 15");
  a_zero_flag: assert property (s_flag_done |=> // [RULE19]
    cur_r.sr[`CAFAB_SR_Z] == ($past(alu.res) == 16'h0000))
    else $error("zero flag wrong");
  a_logic_keeps_sc: assert property ((s_flag_done ##0 upd_nz // [RULE3]
    ##0 !reg_wr_i) |=> $stable(cur_r.sr[`CAFAB_SR_S:`CAFAB_SR_C]))
    else $error("logic op changed sign or carry");
  a_store_no_flags: assert property (done_w && alu_mode // [RULE3]
    && cur_r.ins.alu == ALU_STORE && !reg_wr_i |=>
    $stable(cur_r.sr[`CAFAB_SR_N:`CAFAB_SR_C]))
    else $error("store changed a flag");
  a_sub_carry: assert property ((s_flag_done ##0 // [RULE2]
    cur_r.ins.alu == ALU_SUB) |=>
    cur_r.sr[`CAFAB_SR_C] == $past(op_a >= op_b))
    else $error("subtract carry wrong");
  a_branch_cc: assert property ((s_branch_done ##0 // [RULE14]
    cur_r.ins.cond == BR_CC) |=> cur_r.pc == ($past(cur_r.sr[`CAFAB_SR_C])
    ? $past(cur_r.pc) + 16'h0001 : $past(cur_r.ins.imm)))
    else $error("carry clear branch wrong");
  a_branch_vs: assert property ((s_branch_done ##0 // [RULE15]
    cur_r.ins.cond == BR_VS && cur_r.sr[`CAFAB_SR_N] != cur_r.sr[`CAFAB_SR_S])
    |=> cur_r.pc == $past(cur_r.ins.imm))
    else $error("overflow branch not taken");
  a_reg_cycles: assert property (done_w && cur_r.ins.mode == MD_REG // [RULE16]
    && cur_r.ins.rd != 3'h7 |-> elap_r == `CAFAB_CYC_REG + 10'(cur_r.rw))
    else $error("register op cycle count wrong");
  a_pc_extra: assert property (done_w && cur_r.ins.mode == MD_DIR6 // [RULE18]
    && wb_en && cur_r.ins.rd == 3'h7 |->
    elap_r == `CAFAB_CYC_DIR6 + `CAFAB_CYC_PC + 10'd2 * 10'(cur_r.rw))
    else $error("pc destination extra cycle missing");
  a_ds_upper: assert property (mem_o.rd && cur_r.ins.mode == MD_IND // [RULE8]
    && !cur_r.ins.ds_q |-> mem_o.addr[21:16] == 6'h00)
    else $error("upper address not zero");
  a_bank_read: assert property (reg_rd_i && reg_addr_i == 4'h1 |=> // [RULE11]
    reg_rdata_o == ($past(cur_r.fr[`CAFAB_FR_BNK]) ? $past(cur_r.shd[0])
                                                   : $past(cur_r.gen[0])))
    else $error("bank remap wrong");

endmodule : cafab_core
`default_nettype wire

// >>> design/cafab_pkg.sv
package cafab_pkg;

  typedef enum logic [3:0] {ALU_ADD, ALU_ADC, ALU_SUB, ALU_SBC, ALU_CMP,
    ALU_NEG, ALU_XOR, ALU_LOAD, ALU_OR, ALU_AND, ALU_TEST,
    ALU_STORE} cafab_alu_e;

  typedef enum logic [3:0] {MD_REG, MD_IMM6, MD_IMM16, MD_DIR6, MD_DIR16,
    MD_IND, MD_MULTI, MD_DISP, MD_BRANCH, MD_MAC} cafab_mode_e;

  typedef enum logic [3:0] {BR_CC, BR_CS, BR_SC, BR_SS, BR_NE, BR_EQ,
    BR_PL, BR_MI, BR_BE, BR_A, BR_LE, BR_G, BR_VC, BR_VS,
    BR_JMP} cafab_cond_e;

  typedef enum logic [1:0] {IX_NONE, IX_POSTINC, IX_POSTDEC,
    IX_PREINC} cafab_idx_e;

  typedef enum logic [2:0] {SH_NONE, SH_ASR, SH_LSL, SH_LSR, SH_ROL,
    SH_ROR} cafab_shift_e;

  typedef enum logic [1:0] {ST_IDLE, ST_ACC, ST_PAD} cafab_st_e;

  typedef struct packed {
    cafab_mode_e  mode;
    cafab_alu_e   alu;
    logic [2:0]   rd;
    logic [2:0]   rs;
    cafab_shift_e shift;
    logic [1:0]   sh_amt;
    cafab_idx_e   idx;
    logic         ds_q;
    logic         push;
    cafab_cond_e  cond;
    logic [3:0]   cnt;
    logic [15:0]  imm;
  } cafab_instr_s;

  typedef struct packed {
    logic        rd;
    logic        wr;
    logic [21:0] addr;
    logic [15:0] wdata;
  } cafab_mem_s;

  typedef struct packed {
    logic [15:0] res;
    logic        n;
    logic        z;
    logic        s;
    logic        c;
  } cafab_alu_s;

  typedef struct packed {
    cafab_st_e        st;
    cafab_instr_s     ins;
    logic [9:0]       cnt;
    logic [3:0]       wcnt;
    logic [3:0]       left;
    logic [2:0]       cur;
    logic [15:0]      mdat;
    cafab_mem_s       mem;
    logic [15:0]      sp;
    logic [15:0]      bp;
    logic [15:0]      sr;
    logic [15:0]      fr;
    logic [15:0]      pc;
    logic [3:0][15:0] gen;
    logic [3:0][15:0] shd;
    logic [3:0]       rw;
    logic [3:0]       sw;
    logic [15:0]      rdata;
  } cafab_state_s;

endpackage : cafab_pkg

// >>> design/cafab_regs.svh
`ifndef CAFAB_REGS_SVH
`define CAFAB_REGS_SVH

// register port offsets (0..7 follow the register select code)
`define CAFAB_OFS_FLAG   4'h8
`define CAFAB_OFS_RWAIT  4'h9
`define CAFAB_OFS_SWAIT  4'hA
`define CAFAB_OFS_STATE  4'hB

// status word fields
`define CAFAB_SR_DS_HI   15
`define CAFAB_SR_DS_LO   10
`define CAFAB_SR_N       9
`define CAFAB_SR_Z       8
`define CAFAB_SR_S       7
`define CAFAB_SR_C       6

// flag word fields
`define CAFAB_FR_BNK     13
`define CAFAB_FR_FIR     11

// reset values
`define CAFAB_RST_WORD   16'h0000
`define CAFAB_RST_WAIT   4'h0

// base cycle counts
`define CAFAB_CYC_REG    10'd3
`define CAFAB_CYC_REG_PC 10'd2
`define CAFAB_CYC_PC     10'd1
`define CAFAB_CYC_IMM6   10'd2
`define CAFAB_CYC_IMM16  10'd4
`define CAFAB_CYC_DIR6   10'd5
`define CAFAB_CYC_DIR16  10'd7
`define CAFAB_CYC_IND    10'd6
`define CAFAB_CYC_DISP   10'd6
`define CAFAB_CYC_MULTI  10'd4
`define CAFAB_CYC_BR     10'd2
`define CAFAB_CYC_BR_TK  10'd4
`define CAFAB_CYC_MAC    10'd6
`define CAFAB_CYC_MAC_N  10'd10

`endif

// >>> tb/cafab_core_bench.sv
`timescale 1ns/10ps
`default_nettype none
module cafab_core_bench;
  import cafab_pkg::*;
  logic         core_clk_i = 1'b0;
  logic         rst_n_i = 1'b0;
  cafab_instr_s instr = '0;
  logic         valid = 1'b0;
  logic         ready, done, reg_wr = 1'b0, reg_rd = 1'b0;
  cafab_mem_s   mem;
  logic [15:0]  mem_rdata, reg_rdata, reg_wdata = 16'h0000;
  logic [3:0]   reg_addr = 4'h0;
  integer       seed = 99;
  int           n_mismatch = 0;
  int           total_checks = 0;
  logic [15:0]  memv [64];
  logic [15:0]  a, b, srv;
  logic [31:0]  x;
  cafab_instr_s ins;
  always #4 core_clk_i = ~core_clk_i;
  cafab_core dut (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i),
    .instr_i(instr), .instr_valid_i(valid), .instr_ready_o(ready),
    .done_o(done), .mem_o(mem), .mem_rdata_i(mem_rdata),
    .reg_addr_i(reg_addr), .reg_wdata_i(reg_wdata), .reg_wr_i(reg_wr),
    .reg_rd_i(reg_rd), .reg_rdata_o(reg_rdata));
  cafab_mem_model mem_model (.core_clk_i(core_clk_i), .mem_i(mem),
    .rdata_o(mem_rdata));
  // result and status word expected from an alu operation
  function automatic logic [31:0] alu_exp(input cafab_alu_e op,
    input logic [15:0] a, input logic [15:0] b, input logic [15:0] sr);
    logic [16:0] u, v;
    logic [15:0] nb, r;
    logic        ci;
    if (op == ALU_STORE) return {a, sr};
    nb = (op inside {ALU_SUB, ALU_SBC, ALU_CMP}) ? ~b : b;
    ci = (op inside {ALU_ADC, ALU_SBC}) ? sr[6] : op inside {ALU_SUB, ALU_CMP};
    u = {1'b0, a} + {1'b0, nb} + ci;
    v = {a[15], a} + {nb[15], nb} + ci;
    case (op)
      ALU_NEG: r = ~b + 16'h0001;
      ALU_XOR: r = a ^ b;
      ALU_LOAD: r = b;
      ALU_OR: r = a | b;
      ALU_AND, ALU_TEST: r = a & b;
      default: r = u[15:0];
    endcase
    sr[9] = r[15];
    sr[8] = (r == 16'h0000);
    if (op <= ALU_CMP) sr[7:6] = {v[16], u[16]};
    return {(op inside {ALU_CMP, ALU_TEST}) ? a : r, sr};
  endfunction : alu_exp
  // branch decision from the status flags
  function automatic logic br_exp(input cafab_cond_e c, input logic [15:0] sr);
    logic n, z, s, cy;
    logic [14:0] t;
    {n, z, s, cy} = sr[9:6];
    t = {1'b1, n != s, n == s, !z && !s, z || s, !z && cy, z || !cy,
         n, !n, z, !z, s, !s, cy, !cy};
    return t[c];
  endfunction : br_exp
  task automatic chk(input string nm, input logic [15:0] e,
                     input logic [15:0] g);
    total_checks++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic final_report();
    if (n_mismatch == 0 && total_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : final_report
  task automatic wr(input logic [3:0] ad, input logic [15:0] d);
    @(posedge core_clk_i);
    reg_wr <= 1'b1;
    reg_addr <= ad;
    reg_wdata <= d;
    @(posedge core_clk_i);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rchk(input logic [3:0] ad, input logic [15:0] ex,
                      input string nm);
    @(posedge core_clk_i);
    reg_rd <= 1'b1;
    reg_addr <= ad;
    @(posedge core_clk_i);
    reg_rd <= 1'b0;
    #1 chk(nm, ex, reg_rdata);
  endtask : rchk
  // offer one instruction, count cycles up to done
  task automatic run(input cafab_instr_s i, input int cyc);
    int k;
    @(posedge core_clk_i);
    instr <= i;
    valid <= 1'b1;
    @(posedge core_clk_i);
    valid <= 1'b0;
    k = 1; // cycle 1 follows the take edge
    do
      @(posedge core_clk_i) #1 k++;
    while (done !== 1'b1 && k < 60);
    chk("cycles", cyc[15:0], k[15:0]);
    chk("busy", 16'h0000, {15'h0, ready});
    if (k >= 60) final_report();
  endtask : run
  // main sequence: reset, port, bank, alu, branch, memory
  initial
  begin
    for (int i = 0; i < 64; i++)
      memv[i] = 16'($random(seed));
    mem_model.mem = memv;
    repeat (4) @(posedge core_clk_i);
    rst_n_i <= 1'b1;
    wr(4'hC, 16'h5A5A);
    for (int i = 0; i < 13; i++)
      rchk(i[3:0], 16'h0000, "reset");
    wr(4'h9, 16'h0001);
    wr(4'hA, 16'h0002);
    wr(4'h1, 16'h1111);
    wr(4'h8, 16'h2000);
    wr(4'h1, 16'h2222);
    rchk(4'h1, 16'h2222, "shadow");
    wr(4'h8, 16'h0000);
    rchk(4'h1, 16'h1111, "general");
    for (int k = 0; k < 80; k++)
    begin
      {a, b, srv} = 48'({$random(seed), $random(seed)});
      if (k < 11) b = a;
      ins = '0;
      ins.mode = (k < 44) ? MD_REG : (k < 74) ? MD_BRANCH : MD_DIR6;
      ins.alu = (k < 44) ? cafab_alu_e'(k % 11) : ALU_ADD;
      if (k > 74) ins.alu = (k == 75) ? ALU_STORE : ALU_LOAD;
      if (k > 75) ins.mode = (k == 76) ? MD_IND : (k == 77) ? MD_IMM6
                           : (k == 78) ? MD_DISP : MD_DIR6;
      {ins.rd, ins.rs, ins.idx} = {(k == 79) ? 3'h7 : 3'h1, 3'h2, IX_POSTINC};
      {ins.cond, ins.imm} = {cafab_cond_e'(k % 15), 10'h000, srv[15:10]};
      if (k >= 44) b = ins.imm;
      wr(4'h1, a);
      wr(4'h2, b);
      wr(4'h6, srv);
      wr(4'h7, 16'h0100);
      x = alu_exp(ins.alu, a, (k < 44 || k == 77) ? b : memv[b[5:0]], srv);
      if (ins.mode == MD_REG) run(ins, 4);
      if (ins.mode == MD_BRANCH)
        run(ins, br_exp(ins.cond, srv) ? 5 : 3);
      if (k > 73)
        run(ins, (k == 77) ? 3 : (k == 74) ? 7 : 8);
      if (ins.mode == MD_BRANCH) x = {a, srv};
      if (k == 75) memv[b[5:0]] = a;
      chk("memory", memv[b[5:0]], mem_model.mem[b[5:0]]);
      rchk(4'h1, (k == 79) ? a : x[31:16],
           "result");
      rchk(4'h6, x[15:0], "status");
      rchk(4'h2, b + {15'h0, k == 76}, "index");
      rchk(4'h7, (ins.mode == MD_BRANCH && br_exp(ins.cond, srv)) ? ins.imm
           : (k == 79) ? x[31:16] : 16'h0101, "pc");
    end
    final_report();
  end
endmodule : cafab_core_bench
`default_nettype wire

// >>> tb/cafab_mem_model.sv
`timescale 1ns/10ps
`default_nettype none
module cafab_mem_model
  import cafab_pkg::*;
(
  input  wire logic                  core_clk_i, // core clock
  input  wire cafab_pkg::cafab_mem_s mem_i,      // request from core
  output logic [15:0]                rdata_o     // read data
);
  logic [15:0] mem [64];
  logic [15:0] last_r = 16'hA5A5;
  // read data only while selected, changing pattern otherwise
  assign rdata_o = mem_i.rd ? mem[mem_i.addr[5:0]] : ~last_r;
  // stores land on every clock edge while the write strobe is high
  always @(posedge core_clk_i)
  begin
    if (mem_i.wr) mem[mem_i.addr[5:0]] <= mem_i.wdata;
    last_r <= rdata_o;
  end
endmodule : cafab_mem_model
`default_nettype wire
